// >>> design/scem_expander.sv
`timescale 1ns/10ps
module scem_expander (
    // Clock and reset.
    input  wire logic       clock,
    input  wire logic       nrst,
    // Serial control bus, open-drain data.
    input  wire logic       i2c_scl,
    input  wire logic       i2c_sda_in,
    output logic            i2c_sda_out,
    output logic            i2c_sda_oe,
    // Sensor side of the flex cable.
    input  wire logic       sensor_strobe,
    output logic            sensor_supply_enable,
    output logic            sensor_reset_n,
    output logic            sensor_trigger,
    // Auxiliary connector and lamps.
    input  wire logic       ext_trigger_in,
    input  wire logic       aux_overcurrent,
    output logic            aux_output_pin_out,
    output logic            aux_output_pin_oe,
    output logic            green_status_lamp,
    output logic            red_overcurrent_lamp,
    // Clock generator register window.
    output logic [7:0]      clkgen_addr,
    output logic [7:0]      clkgen_wdata,
    output logic            clkgen_wr,
    input  wire logic [7:0] clkgen_rdata
);

    // ****************************************************************
    // Pin synchronisation.
    // ****************************************************************
    scem_pkg::scem_pins_t pins_raw;
    scem_pkg::scem_pins_t pins;

    // Bus lines, strobe and overcurrent sense pass two flops first.
    assign pins_raw.scl         = i2c_scl;
    assign pins_raw.sda         = i2c_sda_in;
    assign pins_raw.strobe      = sensor_strobe;
    assign pins_raw.overcurrent = aux_overcurrent;

    scem_sync #(
        .WIDTH (scem_pkg::SCEM_SYNC_WIDTH)
    ) u_sync (
        .clock    (clock),
        .nrst     (nrst),
        .async_in (pins_raw),
        .sync_out (pins)
    );

    // ****************************************************************
    // Bus edge and condition detection.
    // ****************************************************************
    logic scl_prev;
    logic sda_prev;
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;

    // Previous synchronised levels, for edge detection.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            scl_prev <= 1'b1;
            sda_prev <= 1'b1;
        end else begin
            scl_prev <= pins.scl;
            sda_prev <= pins.sda;
        end
    end

    // Data changing while the clock is high marks start or stop.
    assign scl_rise   = pins.scl & ~scl_prev;
    assign scl_fall   = ~pins.scl & scl_prev;
    assign start_cond = pins.scl & scl_prev & sda_prev & ~pins.sda;
    assign stop_cond  = pins.scl & scl_prev & ~sda_prev & pins.sda;

    // ****************************************************************
    // Serial target state.
    // ****************************************************************
    scem_pkg::scem_state_t state;
    scem_pkg::scem_state_t next_state;
    scem_pkg::scem_port_t  port;
    scem_pkg::scem_port_t  next_port;
    logic [3:0]            bit_cnt;
    logic [3:0]            next_bit_cnt;
    logic [7:0]            shift;
    logic [7:0]            next_shift;
    logic                  sda_oe;
    logic                  next_sda_oe;
    logic                  to_clkgen;
    logic                  next_to_clkgen;
    logic                  is_read;
    logic                  next_is_read;
    logic                  first_byte;
    logic                  next_first_byte;
    logic                  host_nack;
    logic                  next_host_nack;
    logic [7:0]            pointer;
    logic [7:0]            next_pointer;
    logic [7:0]            clk_addr;
    logic [7:0]            next_clk_addr;
    logic [7:0]            clk_wdata;
    logic [7:0]            next_clk_wdata;
    logic                  clk_wr;
    logic                  next_clk_wr;
    logic [7:0]            rd_byte;

    // Byte to send: live pins, output port, direction map or clock window.
    always_comb begin
        if (to_clkgen) begin
            rd_byte = clkgen_rdata;
        end else begin
            unique case (pointer)
                scem_pkg::SCEM_PTR_INPUT:  rd_byte = {pins.strobe, port[6:0]};
                scem_pkg::SCEM_PTR_OUTPUT: rd_byte = {1'b0, port[6:0]};
                scem_pkg::SCEM_PTR_CONFIG: rd_byte = scem_pkg::SCEM_CONFIG_VAL;
                default:                   rd_byte = scem_pkg::SCEM_UNMAPPED;
            endcase
        end
    end

    // Next-state logic: bits sampled on clock rise, data changed on fall.
    always_comb begin
        next_state      = state;
        next_port       = port;
        next_bit_cnt    = bit_cnt;
        next_shift      = shift;
        next_sda_oe     = sda_oe;
        next_to_clkgen  = to_clkgen;
        next_is_read    = is_read;
        next_first_byte = first_byte;
        next_host_nack  = host_nack;
        next_pointer    = pointer;
        next_clk_addr   = clk_addr;
        next_clk_wdata  = clk_wdata;
        next_clk_wr     = 1'b0;
        if (start_cond) begin
            next_state   = scem_pkg::SCEM_ADDR;
            next_bit_cnt = '0;
            next_sda_oe  = 1'b0;
        end else if (stop_cond) begin
            next_state  = scem_pkg::SCEM_IDLE;
            next_sda_oe = 1'b0;
        end else begin
            unique case (state)
                scem_pkg::SCEM_IDLE: begin
                    next_sda_oe = 1'b0;
                end
                scem_pkg::SCEM_ADDR: begin
                    if (scl_rise) begin
                        next_shift   = {shift[6:0], pins.sda};
                        next_bit_cnt = bit_cnt + 4'h1;
                    end else if (scl_fall && bit_cnt == scem_pkg::SCEM_BYTE_BITS) begin
                        next_is_read   = shift[0];
                        next_to_clkgen = (shift[7:1] == scem_pkg::SCEM_CLK_ADDR);
                        if (shift[7:1] == scem_pkg::SCEM_EXP_ADDR ||
                            shift[7:1] == scem_pkg::SCEM_CLK_ADDR) begin
                            next_state  = scem_pkg::SCEM_ADDR_ACK;
                            next_sda_oe = 1'b1;
                        end else begin
                            next_state = scem_pkg::SCEM_IDLE;
                        end
                    end
                end
                scem_pkg::SCEM_ADDR_ACK: begin
                    if (scl_fall) begin
                        next_bit_cnt    = '0;
                        next_first_byte = 1'b1;
                        if (is_read) begin
                            next_state  = scem_pkg::SCEM_RD;
                            next_shift  = rd_byte;
                            next_sda_oe = ~rd_byte[7];
                        end else begin
                            next_state  = scem_pkg::SCEM_WR;
                            next_sda_oe = 1'b0;
                        end
                    end
                end
                scem_pkg::SCEM_WR: begin
                    if (scl_rise) begin
                        next_shift   = {shift[6:0], pins.sda};
                        next_bit_cnt = bit_cnt + 4'h1;
                    end else if (scl_fall && bit_cnt == scem_pkg::SCEM_BYTE_BITS) begin
                        next_state      = scem_pkg::SCEM_WR_ACK;
                        next_sda_oe     = 1'b1;
                        if (first_byte) begin
                            next_pointer  = to_clkgen ? pointer : shift;
                            next_clk_addr = to_clkgen ? shift : clk_addr;
                        end else if (to_clkgen) begin
                            next_clk_wdata = shift;
                            next_clk_wr    = 1'b1;
                        end else if (pointer == scem_pkg::SCEM_PTR_OUTPUT) begin
                            next_port           = shift;
                            next_port.strobe_in = 1'b0;
                        end
                    end
                end
                scem_pkg::SCEM_WR_ACK: begin
                    if (scl_fall) begin
                        next_state      = scem_pkg::SCEM_WR;
                        next_sda_oe     = 1'b0;
                        next_bit_cnt    = '0;
                        next_first_byte = 1'b0;
                        // The address byte itself must not advance the window address.
                        if (to_clkgen && !first_byte) begin
                            next_clk_addr = clk_addr + 8'h01;
                        end
                    end
                end
                scem_pkg::SCEM_RD: begin
                    if (scl_rise) begin
                        next_bit_cnt = bit_cnt + 4'h1;
                    end else if (scl_fall) begin
                        if (bit_cnt == scem_pkg::SCEM_BYTE_BITS) begin
                            next_state  = scem_pkg::SCEM_RD_ACK;
                            next_sda_oe = 1'b0;
                            if (to_clkgen) begin
                                next_clk_addr = clk_addr + 8'h01;
                            end
                        end else begin
                            next_shift  = {shift[6:0], 1'b0};
                            next_sda_oe = ~shift[6];
                        end
                    end
                end
                scem_pkg::SCEM_RD_ACK: begin
                    if (scl_rise) begin
                        next_host_nack = pins.sda;
                    end else if (scl_fall) begin
                        next_bit_cnt = '0;
                        if (host_nack) begin
                            next_state = scem_pkg::SCEM_IDLE;
                        end else begin
                            next_state  = scem_pkg::SCEM_RD;
                            next_shift  = rd_byte;
                            next_sda_oe = ~rd_byte[7];
                        end
                    end
                end
                default: begin
                    next_state  = scem_pkg::SCEM_IDLE;
                    next_sda_oe = 1'b0;
                end
            endcase
        end
    end

    // Registers of the serial target and the output port.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state      <= scem_pkg::SCEM_IDLE;
            port       <= scem_pkg::SCEM_PORT_RESET;
            bit_cnt    <= '0;
            shift      <= '0;
            sda_oe     <= 1'b0;
            to_clkgen  <= 1'b0;
            is_read    <= 1'b0;
            first_byte <= 1'b0;
            host_nack  <= 1'b0;
            pointer    <= scem_pkg::SCEM_PTR_INPUT;
            clk_addr   <= '0;
            clk_wdata  <= '0;
            clk_wr     <= 1'b0;
        end else begin
            state      <= next_state;
            port       <= next_port;
            bit_cnt    <= next_bit_cnt;
            shift      <= next_shift;
            sda_oe     <= next_sda_oe;
            to_clkgen  <= next_to_clkgen;
            is_read    <= next_is_read;
            first_byte <= next_first_byte;
            host_nack  <= next_host_nack;
            pointer    <= next_pointer;
            clk_addr   <= next_clk_addr;
            clk_wdata  <= next_clk_wdata;
            clk_wr     <= next_clk_wr;
        end
    end

    // Open-drain data: the target only ever pulls low.
    assign i2c_sda_out = 1'b0;
    assign i2c_sda_oe  = sda_oe;

    // Clock generator window, one pulse per data byte written.
    assign clkgen_addr  = clk_addr;
    assign clkgen_wdata = clk_wdata;
    assign clkgen_wr    = clk_wr;

    // ****************************************************************
    // Sensor control and signal multiplexers.
    // ****************************************************************
    logic aux_source;

    // Power and reset follow their port bits straight from the flops.
    assign sensor_supply_enable = port.sensor_supply_enable;
    assign sensor_reset_n       = port.sensor_reset_release;

    // Trigger mux is pure logic so the sensor sees no added latency.
    assign sensor_trigger = port.trig_source_select
                          ? (ext_trigger_in ^ port.trig_invert)
                          : ~port.trig_invert;

    // Auxiliary pin source: raw strobe or the level bit.
    assign aux_source = port.aux_output_source_select
                      ? port.aux_output_level_bit
                      : sensor_strobe;

    // A low source always sinks; a high one drives only in push-pull.
    assign aux_output_pin_out = aux_source;
    assign aux_output_pin_oe  = ~aux_source | port.aux_output_drive_type;

    // Green lamp follows the level bit.
    assign green_status_lamp = port.aux_output_level_bit;

    // Red lamp: sensed overcurrent while the pin is driven high in push-pull.
    assign red_overcurrent_lamp = pins.overcurrent & port.aux_output_drive_type
                                & aux_source;

endmodule : scem_expander

// >>> design/scem_pkg.sv
// ****************************************************************
// Shared constants and types of the sensor control expander.
// ****************************************************************
package scem_pkg;

    // ****************************************************************
    // Bus addresses and expander pointer codes.
    // ****************************************************************
    // Seven-bit target address of the port expander.
    localparam logic [6:0] SCEM_EXP_ADDR    = 7'h20;
    // Seven-bit target address of the sensor clock generator window.
    localparam logic [6:0] SCEM_CLK_ADDR    = 7'h70;
    // Pointer that reads the live pin levels.
    localparam logic [7:0] SCEM_PTR_INPUT   = 8'h00;
    // Pointer that reads and writes the output port.
    localparam logic [7:0] SCEM_PTR_OUTPUT  = 8'h01;
    // Pointer that reads the fixed direction map.
    localparam logic [7:0] SCEM_PTR_CONFIG  = 8'h03;
    // Direction map: only the strobe bit is an input.
    localparam logic [7:0] SCEM_CONFIG_VAL  = 8'h80;
    // Output port after reset: power off, sensor held in reset.
    localparam logic [7:0] SCEM_PORT_RESET  = 8'h00;
    // Read value of any pointer that names no register.
    localparam logic [7:0] SCEM_UNMAPPED    = 8'h00;
    // Data bits in one bus byte.
    localparam logic [3:0] SCEM_BYTE_BITS   = 4'h8;
    // Number of pin inputs that pass the synchroniser.
    localparam int         SCEM_SYNC_WIDTH  = 4;

    // ****************************************************************
    // Expander port layout, bit 7 down to bit 0.
    // ****************************************************************
    typedef struct packed {
        logic strobe_in;                 // Bit 7, input only.
        logic trig_source_select;        // Bit 6, 1 selects external.
        logic trig_invert;               // Bit 5, 1 inverts trigger.
        logic aux_output_source_select;  // Bit 4, 1 selects level bit.
        logic aux_output_drive_type;     // Bit 3, 1 is push-pull.
        logic aux_output_level_bit;      // Bit 2.
        logic sensor_reset_release;      // Bit 1, 0 holds reset.
        logic sensor_supply_enable;      // Bit 0, 1 powers sensor.
    } scem_port_t;

    // Pin inputs that are synchronised before the logic reads them.
    typedef struct packed {
        logic scl;
        logic sda;
        logic strobe;
        logic overcurrent;
    } scem_pins_t;

    // Serial target states, Gray coded along the usual path.
    typedef enum logic [2:0] {
        SCEM_IDLE     = 3'h0,
        SCEM_ADDR     = 3'h1,
        SCEM_ADDR_ACK = 3'h3,
        SCEM_WR       = 3'h2,
        SCEM_WR_ACK   = 3'h6,
        SCEM_RD       = 3'h7,
        SCEM_RD_ACK   = 3'h5
    } scem_state_t;

endpackage : scem_pkg

// >>> design/scem_sync.sv
`timescale 1ns/10ps
// ****************************************************************
// Two flip-flop synchroniser bank, one chain per bit.
// ****************************************************************
module scem_sync #(
    parameter int WIDTH = 4
) (
    // Clock and reset.
    input  wire logic             clock,
    input  wire logic             nrst,
    // Asynchronous inputs and their synchronised copies.
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage_one;

    // Each bit passes two flops; only the second flop reads the first.
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge clock or negedge nrst) begin
                if (!nrst) begin
                    stage_one[i] <= 1'b0;
                    sync_out[i]  <= 1'b0;
                end else begin
                    stage_one[i] <= async_in[i];
                    sync_out[i]  <= stage_one[i];
                end
            end
        end
    endgenerate

endmodule : scem_sync

// >>> verif/scem_expander_chk.sv
`timescale 1ns/10ps
// ********************
// Port checker of the sensor control expander.
// ********************
module scem_expander_chk (
    // Clock and reset.
    input wire logic clock,
    input wire logic nrst,
    // Serial bus pins.
    input wire logic i2c_scl,
    input wire logic i2c_sda_out,
    input wire logic i2c_sda_oe,
    // Port outputs, pins and lamps.
    input wire logic sensor_supply_enable,
    input wire logic sensor_reset_n,
    input wire logic green_status_lamp,
    input wire logic aux_overcurrent,
    input wire logic aux_output_pin_out,
    input wire logic aux_output_pin_oe,
    input wire logic red_overcurrent_lamp,
    input wire logic clkgen_wr
);
    // All checks share the one clock and its reset.
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    sda_open_drain_a: assert property (
        i2c_sda_out == 1'b0) else $error("sda driven high");
    ack_phase_a: assert property (
        $rose(i2c_sda_oe) |-> !i2c_scl && !$past(i2c_scl, 2))
        else $error("sda pulled outside the low phase");
    reset_state_a: assert property (
        !$past(nrst) |-> !sensor_supply_enable && !sensor_reset_n && !green_status_lamp
        && !clkgen_wr) else $error("outputs not idle after reset");
    port_commit_a: assert property (
        $changed({sensor_supply_enable, sensor_reset_n, green_status_lamp}) |-> !i2c_scl)
        else $error("port changed while scl high");
    wr_pulse_a: assert property (
        clkgen_wr |=> !clkgen_wr) else $error("clock window write longer than a cycle");
    wr_phase_a: assert property (
        clkgen_wr |-> !i2c_scl) else $error("clock window write while scl high");
    aux_low_a: assert property (
        !aux_output_pin_out |-> aux_output_pin_oe) else $error("aux low level not driven");
    red_mode_a: assert property (
        red_overcurrent_lamp |-> aux_output_pin_oe && aux_output_pin_out)
        else $error("red lamp without push-pull high drive");
    red_sense_a: assert property (
        $rose(red_overcurrent_lamp) |-> $past(aux_overcurrent, 2))
        else $error("red lamp without overcurrent");
endmodule : scem_expander_chk

bind scem_expander scem_expander_chk chk (.clock, .nrst, .i2c_scl, .i2c_sda_out, .i2c_sda_oe,
    .sensor_supply_enable, .sensor_reset_n, .green_status_lamp, .aux_overcurrent,
    .aux_output_pin_out, .aux_output_pin_oe, .red_overcurrent_lamp, .clkgen_wr);

// >>> verif/scem_host.sv
`timescale 1ns/10ps
// ********************
// Serial bus host model.
// ********************
module scem_host (
    // Clock and bus wire level.
    input  wire logic clock,
    input  wire logic sda,
    // Bus pins driven by the host.
    output logic      scl,
    output logic      sda_low
);
    // The bus idles with both lines released.
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    // Each bus phase lasts ten clocks, well above the four-clock minimum.
    task automatic hold();
        repeat (10) @(negedge clock);
    endtask : hold

    // Start condition, also used as a repeated start.
    task automatic start();
        sda_low = 1'b0;
        hold();
        scl = 1'b1;
        hold();
        sda_low = 1'b1;
        hold();
        scl = 1'b0;
        hold();
    endtask : start

    // Stop condition releases data while the clock is high.
    task automatic stop();
        sda_low = 1'b1;
        hold();
        scl = 1'b1;
        hold();
        sda_low = 1'b0;
        hold();
    endtask : stop

    // One bit: data set in the low phase, sampled at the end of the high phase.
    task automatic bit_io(input logic b, output logic r);
        sda_low = !b;
        hold();
        scl = 1'b1;
        hold();
        r = sda;
        scl = 1'b0;
        hold();
    endtask : bit_io

    // Sends a byte most significant bit first and returns the acknowledge.
    task automatic send(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], r);
        end
        bit_io(1'b1, r);
        ack = !r;
    endtask : send

    // Receives a byte; a set last flag answers with no acknowledge.
    task automatic recv(input logic last, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, b[i]);
        end
        bit_io(last, r);
    endtask : recv
endmodule : scem_host

// >>> verif/tb.sv
`timescale 1ns/10ps
// ********************
// Self-checking bench of the sensor control expander.
// ********************
module tb;
    // Clock, reset and design pins.
    logic       clock = 1'b0;
    logic       nrst = 1'b0;
    logic       ext_trigger_in = 1'b0, aux_overcurrent = 1'b0, sensor_strobe = 1'b0;
    logic       i2c_scl, i2c_sda_in, i2c_sda_out, i2c_sda_oe, sda_low, clkgen_wr;
    logic       sensor_supply_enable, sensor_reset_n, sensor_trigger, green_status_lamp;
    logic       aux_output_pin_out, aux_output_pin_oe, red_overcurrent_lamp, ack, src;
    logic [7:0] clkgen_addr, clkgen_wdata, clkgen_rdata, wr_addr, wr_data, rd;
    int         fails = 0, compares = 0, wr_count = 0;

    // The clock toggles every half period.
    always #5 clock = ~clock;
    // The data wire has a pull-up and is low while any party pulls it.
    assign i2c_sda_in = !(sda_low || i2c_sda_oe);
    // The clock generator registers answer the complement of their address.
    assign clkgen_rdata = ~clkgen_addr;

    scem_expander dut (.clock, .nrst, .i2c_scl, .i2c_sda_in, .i2c_sda_out, .i2c_sda_oe,
        .sensor_strobe, .sensor_supply_enable, .sensor_reset_n, .sensor_trigger,
        .ext_trigger_in, .aux_overcurrent, .aux_output_pin_out, .aux_output_pin_oe,
        .green_status_lamp, .red_overcurrent_lamp, .clkgen_addr, .clkgen_wdata,
        .clkgen_wr, .clkgen_rdata);
    scem_host host (.clock, .sda(i2c_sda_in), .scl(i2c_scl), .sda_low);

    // Records each write strobe towards the clock generator.
    always @(negedge clock) begin
        if (clkgen_wr === 1'b1) begin
            wr_addr <= clkgen_addr;
            wr_data <= clkgen_wdata;
            wr_count <= wr_count + 1;
        end
    end

    // Compares one value and reports a mismatch.
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Writes two bytes to a target; ack keeps the address acknowledge.
    task automatic wr2(input logic [6:0] a, input logic [7:0] b0, input logic [7:0] b1);
        logic k;
        host.start();
        host.send({a, 1'b0}, ack);
        host.send(b0, k);
        host.send(b1, k);
        host.stop();
    endtask : wr2

    // Writes a pointer, then reads one byte after a repeated start.
    task automatic rd1(input logic [6:0] a, input logic [7:0] p);
        logic k;
        host.start();
        host.send({a, 1'b0}, k);
        host.send(p, k);
        host.start();
        host.send({a, 1'b1}, k);
        host.recv(1'b1, rd);
        host.stop();
    endtask : rd1

    // Writes the output port of the expander.
    task automatic set_port(input logic [7:0] v);
        wr2(7'h20, 8'h01, v);
    endtask : set_port

    // Prints the counts and the verdict, then ends the run.
    task automatic tally_and_finish();
        $display("mismatches %0d comparisons %0d", fails, compares);
        if (fails == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : tally_and_finish

    // Cuts a hung run short.
    initial begin
        repeat (90000) @(posedge clock);
        fails++;
        tally_and_finish();
    end

    // Main sequence of bus calls and expected values.
    initial begin
        repeat (3) @(negedge clock);
        nrst = 1'b1;
        repeat (4) @(negedge clock);
        check(8'({sensor_supply_enable, sensor_reset_n, green_status_lamp}), 8'h00);
        check(8'(sensor_trigger), 8'h01);
        check(8'({aux_output_pin_oe, aux_output_pin_out}), 8'h02);
        wr2(7'h21, 8'h01, 8'h03);
        check(8'({ack, sensor_supply_enable}), 8'h00);
        set_port(8'h01);
        check(8'({ack, sensor_supply_enable, sensor_reset_n}), 8'h06);
        set_port(8'h03);
        check(8'({sensor_supply_enable, sensor_reset_n}), 8'h03);
        sensor_strobe = 1'b1;
        rd1(7'h20, 8'h00);
        check(rd, 8'h83);
        sensor_strobe = 1'b0;
        rd1(7'h20, 8'h00);
        check(rd, 8'h03);
        rd1(7'h20, 8'h01);
        check(rd, 8'h03);
        rd1(7'h20, 8'h03);
        check(rd, 8'h80);
        // Every trigger mode and polarity against both external levels.
        for (int m = 0; m < 4; m++) begin
            set_port({1'b0, m[1:0], 5'h03});
            for (int e = 0; e < 2; e++) begin
                @(negedge clock);
                ext_trigger_in = e[0];
                #1;
                check(8'(sensor_trigger), 8'(m[1] ? e[0] ^ m[0] : !m[0]));
            end
        end
        // Every aux source, drive type and level against both strobe levels.
        for (int v = 0; v < 8; v++) begin
            set_port({3'h0, v[2:0], 2'h3});
            for (int s = 0; s < 2; s++) begin
                @(negedge clock);
                sensor_strobe = s[0];
                #1;
                src = v[2] ? v[0] : s[0];
                check(8'(aux_output_pin_oe), 8'(v[1] | !src));
                if (aux_output_pin_oe === 1'b1) check(8'(aux_output_pin_out), 8'(src));
                check(8'(green_status_lamp), 8'(v[0]));
            end
        end
        // Overcurrent lights the red lamp only in push-pull drive.
        @(negedge clock);
        aux_overcurrent = 1'b1;
        repeat (4) @(negedge clock);
        check(8'(red_overcurrent_lamp), 8'h01);
        set_port(8'h17);
        check(8'(red_overcurrent_lamp), 8'h00);
        aux_overcurrent = 1'b0;
        // Clock generator window write and read.
        wr2(7'h70, 8'h10, 8'h55);
        check(8'(wr_count), 8'h01);
        check(wr_addr, 8'h10);
        check(wr_data, 8'h55);
        rd1(7'h70, 8'h22);
        check(rd, 8'hdd);
        // A reset in mid-run returns the port to its idle state.
        nrst = 1'b0;
        @(negedge clock);
        nrst = 1'b1;
        repeat (4) @(negedge clock);
        check(8'({sensor_supply_enable, sensor_reset_n, sensor_trigger}), 8'h01);
        tally_and_finish();
    end
endmodule : tb
